// File: rtl/spi_pkg.sv
// Constants and types shared by the serial register access port
package spi_pkg;

    // -----------------------------------------------------------------
    // Word layout
    // -----------------------------------------------------------------
    localparam int         DATA_W      = 16;
    localparam int         ADDR_W      = 10;
    localparam int         WORD_BITS   = 16;
    localparam int         CNT_W       = 4;
    localparam int         ENABLE_MSB  = 15;
    localparam int         ENABLE_LSB  = 11;
    localparam int         RW_POS      = 10;
    localparam logic [4:0] ENABLE_CODE = 5'h1C;
    localparam logic [3:0] LAST_BIT    = 4'hF;
    localparam logic [9:0] ADDR_LAST   = 10'h3FF;

    // -----------------------------------------------------------------
    // Buffering and pin sampling
    // -----------------------------------------------------------------
    localparam int         FIFO_DEPTH  = 8;
    localparam int         PIN_COUNT   = 3;
    localparam int         PIN_CS      = 0;
    localparam int         PIN_SCLK    = 1;
    localparam int         PIN_DIN     = 2;
    // Chip select idles high, the other pins idle low
    localparam logic [2:0] PIN_RESET   = 3'h1;

    // -----------------------------------------------------------------
    // Frame phases
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE  = 3'b000,
        PH_CMD   = 3'b001,
        PH_WRITE = 3'b010,
        PH_READ  = 3'b011,
        PH_SKIP  = 3'b100
    } phase_t;

endpackage

// File: rtl/fifo_if.sv
// Handshake bundle between the serial port and its write buffer
`timescale 1ns/1ps
interface fifo_if #(
    parameter int W = 26
);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;

    modport fifo (
        input  push_valid,
        input  push_data,
        input  pop_ready,
        output push_ready,
        output pop_valid,
        output pop_data
    );

    modport user (
        output push_valid,
        output push_data,
        output pop_ready,
        input  push_ready,
        input  pop_valid,
        input  pop_data
    );
endinterface

// File: rtl/word_fifo.sv
// Write word buffer with a registered output stage
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 8
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    fifo_if.fifo      q
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wp;
    logic [PW-1:0]    rp;
    logic [CW-1:0]    cnt;
    logic             push_ok;
    logic             load;
    logic             out_valid;
    logic [WIDTH-1:0] out_data;

    assign q.push_ready = (cnt != CNT_FULL);
    assign push_ok      = q.push_valid && q.push_ready;
    // Output register refills whenever it is empty or being taken
    assign load         = (cnt != '0) && (!out_valid || q.pop_ready);
    assign q.pop_valid  = out_valid;
    assign q.pop_data   = out_data;

    always_ff @(posedge clk_i) begin
        if (push_ok) begin
            mem[wp] <= q.push_data;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            if (push_ok) begin
                wp <= (wp == PTR_LAST) ? '0 : wp + 1'b1;
            end
            if (load) begin
                rp <= (rp == PTR_LAST) ? '0 : rp + 1'b1;
            end
            if (push_ok && !load) begin
                cnt <= cnt + 1'b1;
            end else if (!push_ok && load) begin
                cnt <= cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (load) begin
            out_valid <= 1'b1;
            out_data  <= mem[rp];
        end else if (q.pop_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule

// File: rtl/spi_register_access_port.sv
// Four-wire serial slave that reads and writes 16-bit registers
// Operation
// - Sample input on rising serial clock, launch output on falling edge.
// - Port responds only while chip select is held low.
// - First 16 bits form command word; top five bits must be 11100.
// - Command bit 10 set means read, clear means write.
// - Low ten command bits give the first register address.
// - Write: each complete 16-bit data word loads the addressed register; a word that meets a full write buffer is dropped and flagged.
// - Address pointer advances after each written word.
// - Write runs until chip select rises; pointer saturates, extra data dropped.
// - Serial clock may idle at either level between frames.
// - Read: sixteen clocks per word shift register contents out.
// - First read bit goes out on first falling edge after command.
// - Read continues while clocked; at top address last register repeats.
// - Output stays high-impedance unless read data is being shifted.
`timescale 1ns/1ps
module spi_register_access_port #(
    parameter int FIFO_DEPTH = spi_pkg::FIFO_DEPTH
) (
    input  wire logic                        clk_i,
    input  wire logic                        nrst_i,
    input  wire logic                        cs_n_i,
    input  wire logic                        sclk_i,
    input  wire logic                        din_i,
    output logic                             sdo_o,
    output logic                             sdo_oe_o,
    output logic [spi_pkg::ADDR_W-1:0]       rd_addr_o,
    input  wire logic [spi_pkg::DATA_W-1:0]  rd_data_i,
    output logic                             rd_strobe_o,
    output logic                             wr_valid_o,
    input  wire logic                        wr_ready_i,
    output logic [spi_pkg::ADDR_W-1:0]       wr_addr_o,
    output logic [spi_pkg::DATA_W-1:0]       wr_data_o,
    output logic                             overflow_o
);
    import spi_pkg::*;

    localparam int FW = ADDR_W + DATA_W;

    // -----------------------------------------------------------------
    // Pin sampling
    // -----------------------------------------------------------------
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_s3;
    logic [PIN_COUNT-1:0] pin_lvl;
    logic [PIN_COUNT-1:0] pin_rise;
    logic [PIN_COUNT-1:0] pin_fall;

    assign pin_raw = {din_i, sclk_i, cs_n_i};

    // A change is accepted only once two stable samples agree, which
    // keeps a single metastable capture from counting as an edge.
    generate
        for (genvar g = 0; g < PIN_COUNT; g++) begin : g_sync
            logic s1;
            logic s2;
            logic s3;
            logic lvl;
            logic agree;

            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    s1  <= PIN_RESET[g];
                    s2  <= PIN_RESET[g];
                    s3  <= PIN_RESET[g];
                    lvl <= PIN_RESET[g];
                end else begin
                    s1 <= pin_raw[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (agree) begin
                        lvl <= s3;
                    end
                end
            end

            assign agree       = (s2 == s3);
            assign pin_s3[g]   = s3;
            assign pin_lvl[g]  = lvl;
            assign pin_rise[g] = agree && s3 && !lvl;
            assign pin_fall[g] = agree && !s3 && lvl;
        end
    endgenerate

    logic cs_high;
    logic sclk_rise;
    logic sclk_fall;
    logic din_bit;

    assign cs_high   = pin_lvl[PIN_CS];
    // Only edges count, so the resting clock level is irrelevant
    assign sclk_rise = pin_rise[PIN_SCLK] && !cs_high;
    assign sclk_fall = pin_fall[PIN_SCLK] && !cs_high;
    assign din_bit   = pin_s3[PIN_DIN];

    // -----------------------------------------------------------------
    // Frame sequencing
    // -----------------------------------------------------------------
    phase_t              phase;
    phase_t              next_phase;
    logic [CNT_W-1:0]    bit_cnt;
    logic [WORD_BITS-2:0] cmd_sh;
    logic [WORD_BITS-1:0] cmd_full;
    logic                cmd_ok;
    logic                word_end;

    assign cmd_full = {cmd_sh, din_bit};
    assign cmd_ok   = cmd_full[ENABLE_MSB:ENABLE_LSB] == ENABLE_CODE;
    assign word_end = sclk_rise && (bit_cnt == LAST_BIT);

    always_comb begin
        if (!cmd_ok) begin
            next_phase = PH_SKIP;
        end else if (cmd_full[RW_POS]) begin
            next_phase = PH_READ;
        end else begin
            next_phase = PH_WRITE;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase <= PH_IDLE;
        end else if (cs_high) begin
            phase <= PH_IDLE;
        end else begin
            unique case (phase)
                PH_IDLE: begin
                    phase <= PH_CMD;
                end
                PH_CMD: begin
                    if (word_end) begin
                        phase <= next_phase;
                    end
                end
                PH_WRITE, PH_READ, PH_SKIP: begin
                    phase <= phase;
                end
                // Unused codes fall back to idle rather than lock up
                default: begin
                    phase <= PH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bit_cnt <= '0;
        end else if (phase == PH_IDLE || cs_high) begin
            bit_cnt <= '0;
        end else if (sclk_rise && phase != PH_SKIP) begin
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_sh <= '0;
        end else if (phase == PH_CMD && sclk_rise) begin
            cmd_sh <= cmd_full[WORD_BITS-2:0];
        end
    end

    // -----------------------------------------------------------------
    // Address pointer
    // -----------------------------------------------------------------
    logic [ADDR_W-1:0] ptr;
    logic              data_word_end;

    assign data_word_end = word_end &&
                           (phase == PH_WRITE || phase == PH_READ);

    // The pointer saturates instead of wrapping, so a long burst never
    // lands on low addresses again.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ptr <= '0;
        end else if (phase == PH_CMD && word_end) begin
            ptr <= cmd_full[ADDR_W-1:0];
        end else if (data_word_end && ptr != ADDR_LAST) begin
            ptr <= ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_addr_o <= '0;
        end else begin
            rd_addr_o <= ptr;
        end
    end

    // -----------------------------------------------------------------
    // Write path
    // -----------------------------------------------------------------
    fifo_if #(.W(FW)) q ();

    word_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .q      (q)
    );

    logic [WORD_BITS-2:0] wr_sh;
    logic [WORD_BITS-1:0] wr_full;
    logic                 wr_stop;
    logic                 push;

    assign wr_full      = {wr_sh, din_bit};
    // A word only counts once all sixteen bits arrived
    assign push         = data_word_end && phase == PH_WRITE && !wr_stop;
    assign q.push_valid = push;
    assign q.push_data  = {ptr, wr_full};
    assign q.pop_ready  = wr_ready_i;
    assign wr_valid_o   = q.pop_valid;
    assign wr_addr_o    = q.pop_data[FW-1:DATA_W];
    assign wr_data_o    = q.pop_data[DATA_W-1:0];

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_sh <= '0;
        end else if (phase == PH_WRITE && sclk_rise) begin
            wr_sh <= wr_full[WORD_BITS-2:0];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_stop <= 1'b0;
        end else if (phase == PH_IDLE) begin
            wr_stop <= 1'b0;
        end else if (push && ptr == ADDR_LAST) begin
            wr_stop <= 1'b1;
        end
    end

    // The serial link cannot be stalled, so a word meeting a full
    // buffer is lost and flagged instead.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            overflow_o <= 1'b0;
        end else begin
            overflow_o <= push && !q.push_ready;
        end
    end

    // -----------------------------------------------------------------
    // Read path
    // -----------------------------------------------------------------
    logic [DATA_W-2:0] rd_sh;
    logic              rd_load;

    assign rd_load = sclk_fall && phase == PH_READ && bit_cnt == '0;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sdo_o       <= 1'b0;
            rd_sh       <= '0;
            rd_strobe_o <= 1'b0;
        end else begin
            rd_strobe_o <= rd_load;
            if (rd_load) begin
                sdo_o <= rd_data_i[DATA_W-1];
                rd_sh <= rd_data_i[DATA_W-2:0];
            end else if (sclk_fall && phase == PH_READ) begin
                sdo_o <= rd_sh[DATA_W-2];
                rd_sh <= {rd_sh[DATA_W-3:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sdo_oe_o <= 1'b0;
        end else if (cs_high || phase != PH_READ) begin
            sdo_oe_o <= 1'b0;
        end else if (sclk_fall) begin
            sdo_oe_o <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    idle_release_a: assert property (
        cs_high |=> !sdo_oe_o && phase == PH_IDLE
    ) else $error("port active with chip select high");

    cmd_hiz_a: assert property (
        phase == PH_CMD || phase == PH_SKIP |-> !sdo_oe_o
    ) else $error("output driven outside read data");

    skip_quiet_a: assert property (
        phase == PH_SKIP |-> !push ##1 !sdo_oe_o
    ) else $error("ignored frame wrote or drove");

    enable_check_a: assert property (
        phase == PH_CMD && word_end && !cs_high &&
        cmd_full[ENABLE_MSB:ENABLE_LSB] != 5'h1C |=> phase == PH_SKIP
    ) else $error("bad enable pattern accepted");

    dir_read_a: assert property (
        phase == PH_CMD && word_end && !cs_high && cmd_ok &&
        cmd_full[RW_POS] |=> phase == PH_READ && ptr == $past(cmd_full[9:0])
    ) else $error("read command not decoded");

    dir_write_a: assert property (
        phase == PH_CMD && word_end && !cs_high && cmd_ok &&
        !cmd_full[RW_POS] |=> phase == PH_WRITE
    ) else $error("write command not decoded");

    push_addr_a: assert property (
        push |-> phase == PH_WRITE && bit_cnt == 4'hF &&
        q.push_data[FW-1:DATA_W] == ptr
    ) else $error("write word pushed at wrong point");

    ptr_step_a: assert property (
        data_word_end && !cs_high && ptr != ADDR_LAST |=>
        ptr == $past(ptr) + 10'h001
    ) else $error("pointer did not advance");

    ptr_hold_a: assert property (
        data_word_end && ptr == ADDR_LAST |=> ptr == ADDR_LAST
    ) else $error("pointer wrapped");

    stop_drop_a: assert property (
        wr_stop |-> !push
    ) else $error("data written past last address");

    sdo_edge_a: assert property (
        $changed(sdo_o) |-> $past(sclk_fall) && $past(phase) == PH_READ
    ) else $error("output changed off a falling edge");

    oe_first_a: assert property (
        $rose(sdo_oe_o) |-> $past(rd_load) && rd_strobe_o
    ) else $error("first read bit not on first falling edge");

    wr_hold_a: assert property (
        wr_valid_o && !wr_ready_i |=>
        wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o)
    ) else $error("write word changed before it was taken");

    ovf_pulse_a: assert property (
        overflow_o |-> $past(push) && !$past(q.push_ready)
    ) else $error("overflow flagged without a lost word");

endmodule

// File: verif/spi_host_model.sv
// Host-side serial master that frames command and data words
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic clk_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      din_o,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i
);
    // Half of an 80 ns serial period at 5 ns per cycle
    localparam int HALF = 8;

    logic [15:0] tx [0:15];
    logic [15:0] rx [0:15];
    int          n_oe;
    int          n_oe_cmd;

    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        din_o  = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // ---------------------------------------------------------------
    // One frame; sel low keeps chip select high to show it is ignored
    // ---------------------------------------------------------------
    task automatic frame(input int nbits, input logic idle, input logic sel);
        int i;
        n_oe = 0;
        n_oe_cmd = 0;
        @(posedge clk_i);
        sclk_o <= idle;
        cs_n_o <= ~sel;
        hold(HALF);
        // Whole words only, held selected until the last bit is out
        for (i = 0; i < nbits; i++) begin
            sclk_o <= 1'b0;
            din_o  <= tx[i/16][15 - i%16];
            hold(HALF);
            sclk_o <= 1'b1;
            // A released output reads inverted so stale bits cannot pass
            rx[i/16][15 - i%16] = (sdo_oe_i === 1'b1) ? sdo_i : ~sdo_i;
            if (sdo_oe_i === 1'b1) begin
                if (i < 16) begin
                    n_oe_cmd++;
                end else begin
                    n_oe++;
                end
            end
            hold(HALF);
        end
        sclk_o <= idle;
        hold(HALF);
        cs_n_o <= 1'b1;
        // A released line must not keep showing the last bit
        din_o  <= ~din_o;
        hold(2 * HALF);
    endtask
endmodule

// File: verif/spi_register_access_port_tb.sv
// Self-checking bench for the serial register access port
`timescale 1ns/1ps
module spi_register_access_port_tb;
    import spi_pkg::*;

    logic              clk;
    logic              nrst;
    logic              wr_ready;
    logic              cs_n;
    logic              sclk;
    logic              din;
    logic              sdo;
    logic              sdo_oe;
    logic              rd_strobe;
    logic              wr_valid;
    logic              overflow;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] wr_data;
    logic [25:0]       got [$];
    int                n_mismatch;
    int                total_checks;
    int                n_ovf;
    int                n_strobe;

    spi_register_access_port spi_register_access_port_i (
        .clk_i(clk), .nrst_i(nrst), .cs_n_i(cs_n), .sclk_i(sclk),
        .din_i(din), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .rd_addr_o(rd_addr),
        .rd_data_i(rd_data), .rd_strobe_o(rd_strobe),
        .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data), .overflow_o(overflow)
    );

    spi_host_model spi_host_model_i (
        .clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din),
        .sdo_i(sdo), .sdo_oe_i(sdo_oe)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // Register file and write sink on the user side
    // ---------------------------------------------------------------
    // Every address is backed here, so no write leaves the map
    function automatic logic [15:0] reg_val(input logic [9:0] a);
        return {a[5:0], a} ^ 16'h5A3C;
    endfunction

    function automatic logic [15:0] cmd(input logic rw, input logic [9:0] a);
        return {ENABLE_CODE, rw, a};
    endfunction

    always @(posedge clk) begin
        rd_data <= reg_val(rd_addr);
        if (nrst === 1'b1 && wr_valid === 1'b1 && wr_ready === 1'b1) begin
            got.push_back({wr_addr, wr_data});
        end
        if (overflow === 1'b1) begin
            n_ovf++;
        end
        if (rd_strobe === 1'b1) begin
            n_strobe++;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic take(input logic [9:0] a, input logic [15:0] d);
        logic [25:0] w;
        w = (got.size() > 0) ? got.pop_front() : 26'hX;
        check({6'h00, w}, {6'h00, a, d}, "write word");
    endtask

    task automatic give_verdict();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_write_single();
        spi_host_model_i.tx[0] = cmd(1'b0, 10'h081);
        spi_host_model_i.tx[1] = 16'h0000;
        spi_host_model_i.frame(32, 1'b0, 1'b1);
        take(10'h081, 16'h0000);
        spi_host_model_i.tx[0] = cmd(1'b0, 10'h2C5);
        spi_host_model_i.tx[1] = 16'hB4E1;
        spi_host_model_i.frame(32, 1'b1, 1'b1);
        take(10'h2C5, 16'hB4E1);
        check(got.size(), 0, "extra writes");
    endtask

    task automatic t_write_burst();
        spi_host_model_i.tx[0] = cmd(1'b0, 10'h3FD);
        spi_host_model_i.tx[1] = 16'h8001;
        spi_host_model_i.tx[2] = 16'h7FFE;
        spi_host_model_i.tx[3] = 16'hC3A5;
        spi_host_model_i.tx[4] = 16'h1234;
        spi_host_model_i.frame(80, 1'b1, 1'b1);
        take(10'h3FD, 16'h8001);
        take(10'h3FE, 16'h7FFE);
        take(ADDR_LAST, 16'hC3A5);
        check(got.size(), 0, "write past top");
    endtask

    task automatic t_read();
        int s0;
        spi_host_model_i.tx[0] = cmd(1'b1, 10'h3FE);
        spi_host_model_i.frame(64, 1'b0, 1'b1);
        check(spi_host_model_i.n_oe_cmd, 0, "oe in command");
        check(spi_host_model_i.n_oe, 48, "oe in data");
        check(spi_host_model_i.rx[1], reg_val(10'h3FE), "rd0");
        check(spi_host_model_i.rx[2], reg_val(10'h3FF), "rd1");
        check(spi_host_model_i.rx[3], reg_val(10'h3FF), "rd2");
        s0 = n_strobe;
        spi_host_model_i.tx[0] = cmd(1'b1, 10'h005);
        spi_host_model_i.frame(32, 1'b1, 1'b1);
        check(spi_host_model_i.rx[1], reg_val(10'h005), "rd idle");
        check(n_strobe - s0, 1, "word loads");
        check(sdo_oe, 1'b0, "oe after frame");
    endtask

    task automatic t_refused();
        spi_host_model_i.tx[0] = {5'h1E, 1'b1, 10'h010};
        spi_host_model_i.frame(48, 1'b0, 1'b1);
        check(spi_host_model_i.n_oe, 0, "bad read driven");
        spi_host_model_i.tx[0] = {5'h0C, 1'b0, 10'h010};
        spi_host_model_i.tx[1] = 16'hFFFF;
        spi_host_model_i.frame(32, 1'b0, 1'b1);
        check(got.size(), 0, "bad write taken");
        spi_host_model_i.tx[0] = cmd(1'b0, 10'h020);
        spi_host_model_i.tx[1] = 16'h5555;
        spi_host_model_i.frame(32, 1'b0, 1'b0);
        check(got.size(), 0, "write without select");
    endtask

    task automatic t_overflow();
        int k;
        @(posedge clk);
        wr_ready <= 1'b0;
        n_ovf = 0;
        spi_host_model_i.tx[0] = cmd(1'b0, 10'h100);
        for (k = 1; k <= 10; k++) begin
            spi_host_model_i.tx[k] = 16'hA000 + 16'(k);
        end
        // Nine words fit (eight buffered plus the output stage)
        spi_host_model_i.frame(176, 1'b0, 1'b1);
        check(n_ovf, 1, "overflow pulses");
        check(got.size(), 0, "taken while stalled");
        wr_ready <= 1'b1;
        repeat (20) @(posedge clk);
        check(got.size(), FIFO_DEPTH + 1, "drained count");
        for (k = 1; k <= 9; k++) begin
            take(10'h0FF + 10'(k), 16'hA000 + 16'(k));
        end
        check(wr_valid, 1'b0, "valid after drain");
    endtask

    // ---------------------------------------------------------------
    // Main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        wr_ready = 1'b1;
        rd_data = 16'h0000;
        n_mismatch = 0;
        total_checks = 0;
        n_ovf = 0;
        n_strobe = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
        t_write_single();
        t_write_burst();
        t_read();
        t_refused();
        t_overflow();
        give_verdict();
    end

    // The whole sequence needs about 8800 cycles
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
endmodule
